/* src/sdp_data_port.sv */
// data port of a pipelined burst sram: capture, drive and turnaround
`timescale 1ns/1ps
module sdp_data_port
	import sdp_pkg::*;
(
	input  wire logic                           core_clk,
	input  wire logic                           reset,
	input  wire logic                           clock_qualify_n,
	input  wire logic                           chip_sel1_n,
	input  wire logic                           chip_sel2,
	input  wire logic                           chip_sel3_n,
	input  wire logic                           load_n,
	input  wire logic                           write_n,
	input  wire logic [sdp_pkg::SDP_LANES-1:0]  byte_lane_write_n,
	input  wire logic [sdp_pkg::SDP_ADDR_W-1:0] addr,
	input  wire logic                           output_drive_n,
	input  wire logic                           mode_strap,
	input  wire logic [sdp_pkg::SDP_DQ_W-1:0]   data_lines_in,
	output logic      [sdp_pkg::SDP_DQ_W-1:0]   data_lines_out,
	output logic                                data_lines_oe_n,
	input  wire logic [sdp_pkg::SDP_LANES-1:0]  parity_lines_in,
	output logic      [sdp_pkg::SDP_LANES-1:0]  parity_lines_out,
	output logic                                parity_lines_oe_n
);

	import sdp_pkg::*;

	localparam int HI_W = SDP_ADDR_W - SDP_BURST_W;

	sdp_state_s              state_ff;
	sdp_state_s              nxt_state;
	logic [SDP_WORD_W-1:0]   mem [0:(1 << SDP_ADDR_W) - 1];
	logic                    qual;
	logic                    selected;
	logic                    rd_cycle;
	logic                    drive_now;
	logic [SDP_WORD_W-1:0]   pin_word;
	logic [SDP_WORD_W-1:0]   core_word;
	logic [SDP_WORD_W-1:0]   rd_word;
	logic [SDP_BURST_W-1:0]  nxt_beat;
	logic [SDP_BURST_W-1:0]  beat_ofs;
	logic                    fwd_hit;
	logic [SDP_WORD_W-1:0]   buf_out_data;

	// every state change below waits for a qualified edge, except strap capture and oe_n
	assign qual     = ~clock_qualify_n;
	assign selected = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
	assign rd_cycle = (state_ff.cmd.op == SDP_OP_READ);

	assign core_word = mem[state_ff.cmd.addr];
	assign fwd_hit   = state_ff.wp.valid
		& (state_ff.wp.addr == state_ff.cmd.addr);

	genvar g;
	generate
		for (g = 0; g < SDP_LANES; g++)
		begin : g_lane
			// parity bit rides in the top of its own lane
			assign pin_word[g*SDP_LANE_W +: SDP_LANE_W] = {
				parity_lines_in[g],
				data_lines_in[g*SDP_BYTE_W +: SDP_BYTE_W]
			};
			// a read right behind a write to the same word
			// must see the data not yet committed
			assign rd_word[g*SDP_LANE_W +: SDP_LANE_W] =
				(fwd_hit & state_ff.wp.mask[g])
				? state_ff.wp.data[g*SDP_LANE_W +: SDP_LANE_W]
				: core_word[g*SDP_LANE_W +: SDP_LANE_W];
			assign data_lines_out[g*SDP_BYTE_W +: SDP_BYTE_W] =
				buf_out_data[g*SDP_LANE_W +: SDP_BYTE_W];
			assign parity_lines_out[g] =
				buf_out_data[g*SDP_LANE_W + SDP_BYTE_W];
		end
	endgenerate

	assign nxt_beat = state_ff.beat + SDP_BEAT_STEP;

	sdp_burst_seq #(
		.W          (SDP_BURST_W)
	) u_burst_seq (
		.start      (state_ff.base[SDP_BURST_W-1:0]),
		.beat       (nxt_beat),
		.interleave (state_ff.interleave),
		.offset     (beat_ofs)
	);

	// output register: read words queue here and leave only on a
	// qualified edge, so a held clock never drops a word
	sdp_pair_buf #(
		.WIDTH     (SDP_WORD_W),
		.DEPTH     (SDP_BUF_DEPTH)
	) u_out_buf (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (qual & rd_cycle),
		.in_ready  (),
		.in_data   (rd_word),
		.out_valid (),
		// one push and one pop per qualified read edge keeps at most one
		// word queued, so ready needs no path back from in_ready
		.out_ready (qual & rd_cycle),
		.out_data  (buf_out_data)
	);

	always_comb
	begin
		nxt_state = state_ff;
		drive_now = state_ff.drive;

		// strap is caught once after reset; the host holds it after that
		if (!state_ff.strap_done)
		begin
			// undriven strap arrives high, giving interleaved order
			nxt_state.interleave = mode_strap;
			nxt_state.strap_done = 1'b1;
		end

		if (qual)
		begin
			// the pending write commits on this edge
			nxt_state.wp.valid = 1'b0;

			// data phase of a write: pins are inputs, capture them
			if (state_ff.cmd.op == SDP_OP_WRITE)
			begin
				nxt_state.wp.valid = 1'b1;
				nxt_state.wp.addr  = state_ff.cmd.addr;
				nxt_state.wp.data  = pin_word;
				nxt_state.wp.mask  = ~state_ff.cmd.lane_n;
			end

			if (!load_n)
			begin
				nxt_state.base       = addr;
				nxt_state.beat       = SDP_BEAT_FIRST;
				nxt_state.cmd.addr   = addr;
				nxt_state.cmd.lane_n = byte_lane_write_n;
				if (selected)
				begin
					nxt_state.cmd.op = write_n ? SDP_OP_READ
						: SDP_OP_WRITE;
				end
				else
				begin
					nxt_state.cmd.op = SDP_OP_IDLE;
				end
			end
			else
			begin
				// burst beat keeps the access type latched at load
				nxt_state.beat       = nxt_beat;
				nxt_state.cmd.addr   = {state_ff.base[SDP_ADDR_W-1 -: HI_W],
					beat_ofs};
				nxt_state.cmd.lane_n = byte_lane_write_n;
			end

			// only a read data phase may drive; write data phase,
			// deselect and the first cycle out of it stay released
			// a write loaded on this edge owns the next cycle, so it
			// wins over read data that would go out now
			drive_now       = rd_cycle
				& ~(~load_n & selected & ~write_n);
			nxt_state.drive = drive_now;
		end

		// output drive is sampled every edge, qualified or not
		nxt_state.oe_n = output_drive_n | ~drive_now;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= SDP_STATE_RST;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// memory core has no reset; it keeps contents across reset
	always_ff @(posedge core_clk)
	begin
		if (qual && state_ff.wp.valid)
		begin
			for (int i = 0; i < SDP_LANES; i++)
			begin
				if (state_ff.wp.mask[i])
				begin
					mem[state_ff.wp.addr][i*SDP_LANE_W +: SDP_LANE_W] <=
						state_ff.wp.data[i*SDP_LANE_W +: SDP_LANE_W];
				end
			end
		end
	end

	assign data_lines_oe_n   = state_ff.oe_n;
	assign parity_lines_oe_n = state_ff.oe_n;

endmodule // sdp_data_port

/* src/sdp_pkg.sv */
// shared constants and types for the sram data port
package sdp_pkg;

	localparam int SDP_LANES     = 4;
	localparam int SDP_BYTE_W    = 8;
	localparam int SDP_LANE_W    = SDP_BYTE_W + 1;
	localparam int SDP_DQ_W      = SDP_LANES * SDP_BYTE_W;
	localparam int SDP_WORD_W    = SDP_LANES * SDP_LANE_W;
	localparam int SDP_ADDR_W    = 18;
	localparam int SDP_BURST_W   = 2;
	localparam int SDP_BUF_DEPTH = 2;

	localparam logic [SDP_BURST_W-1:0] SDP_BEAT_FIRST = 2'h0;
	localparam logic [SDP_BURST_W-1:0] SDP_BEAT_STEP  = 2'h1;

	// strap reads high when nothing pulls it, so interleaved is the reset order
	localparam logic SDP_ORDER_RST = 1'h1;
	localparam logic SDP_OE_N_RST  = 1'h1;

	typedef enum logic [2:0] {
		SDP_OP_IDLE  = 3'b001,
		SDP_OP_READ  = 3'b010,
		SDP_OP_WRITE = 3'b100
	} sdp_op_e;

	typedef struct packed {
		sdp_op_e                op;
		logic [SDP_ADDR_W-1:0]  addr;
		logic [SDP_LANES-1:0]   lane_n;
	} sdp_cmd_s;

	typedef struct packed {
		logic                   valid;
		logic [SDP_ADDR_W-1:0]  addr;
		logic [SDP_WORD_W-1:0]  data;
		logic [SDP_LANES-1:0]   mask;
	} sdp_wpend_s;

	typedef struct packed {
		sdp_cmd_s               cmd;
		logic [SDP_ADDR_W-1:0]  base;
		logic [SDP_BURST_W-1:0] beat;
		sdp_wpend_s             wp;
		logic                   interleave;
		logic                   strap_done;
		logic                   drive;
		logic                   oe_n;
	} sdp_state_s;

	localparam sdp_state_s SDP_STATE_RST = '{
		cmd:        '{op: SDP_OP_IDLE, addr: '0, lane_n: '1},
		base:       '0,
		beat:       SDP_BEAT_FIRST,
		wp:         '{valid: 1'b0, addr: '0, data: '0, mask: '0},
		interleave: SDP_ORDER_RST,
		strap_done: 1'b0,
		drive:      1'b0,
		oe_n:       SDP_OE_N_RST
	};

endpackage

/* src/sdp_burst_seq.sv */
// burst address low bits, linear or interleaved order
`timescale 1ns/1ps
module sdp_burst_seq #(
	parameter int W = 2
) (
	input  wire logic [W-1:0] start,
	input  wire logic [W-1:0] beat,
	input  wire logic         interleave,
	output logic      [W-1:0] offset
);

	always_comb
	begin
		if (interleave)
		begin
			offset = start ^ beat;
		end
		else
		begin
			// wraps inside the burst because the sum is cut to W bits
			offset = W'(start + beat);
		end
	end

endmodule // sdp_burst_seq

/* src/sdp_pair_buf.sv */
// small shift fifo whose head entry is a register
`timescale 1ns/1ps
module sdp_pair_buf #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
		logic [CW-1:0]               count;
	} sdp_buf_s;

	sdp_buf_s      buf_ff;
	sdp_buf_s      nxt_buf;
	logic          push;
	logic          pop;
	logic [CW-1:0] wr_idx;

	assign in_ready  = (buf_ff.count < CW'(DEPTH)) | out_ready;
	assign out_valid = (buf_ff.count != '0);
	assign out_data  = buf_ff.entry[0];
	assign pop       = out_valid & out_ready;
	assign push      = in_valid & in_ready;
	assign wr_idx    = buf_ff.count - CW'(pop);

	always_comb
	begin
		nxt_buf = buf_ff;
		if (pop)
		begin
			// entries slide toward the head so the output never goes through a mux
			for (int i = 0; i < DEPTH - 1; i++)
			begin
				nxt_buf.entry[i] = buf_ff.entry[i + 1];
			end
		end
		if (push)
		begin
			nxt_buf.entry[wr_idx] = in_data;
		end
		nxt_buf.count = buf_ff.count + CW'(push) - CW'(pop);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			buf_ff <= '0;
		end
		else
		begin
			buf_ff <= nxt_buf;
		end
	end

endmodule // sdp_pair_buf

/* tb/sdp_host_model.sv */
// host controller model driving write words onto the shared pins
`timescale 1ns/1ps
module sdp_host_model
	import sdp_pkg::*;
(
	input	wire logic			core_clk,
	input	wire logic			send,
	input	wire logic [sdp_pkg::SDP_WORD_W-1:0]	word,
	output	logic [sdp_pkg::SDP_WORD_W-1:0]		pins
);
	logic [SDP_WORD_W-1:0]	last_ff = '0;

	// released pins show the inverse, so a stale word is never read
	assign pins = send ? word : ~last_ff;

	always_ff @(posedge core_clk)
	begin
		if (send)
			last_ff <= word;
	end
endmodule // sdp_host_model

/* tb/sdp_data_port_assertions.sv */
// pin level checks for the sram data port
`timescale 1ns/1ps
module sdp_port_assertions
	import sdp_pkg::*;
(
	input	wire logic		core_clk,
	input	wire logic		reset,
	input	wire logic		clock_qualify_n,
	input	wire logic		chip_sel1_n,
	input	wire logic		chip_sel2,
	input	wire logic		chip_sel3_n,
	input	wire logic		load_n,
	input	wire logic		write_n,
	input	wire logic		output_drive_n,
	input	wire logic [sdp_pkg::SDP_DQ_W-1:0]	data_lines_out,
	input	wire logic		data_lines_oe_n,
	input	wire logic [sdp_pkg::SDP_LANES-1:0]	parity_lines_out,
	input	wire logic		parity_lines_oe_n
);
	wire qual = !clock_qualify_n;
	wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	wire ld = qual && !load_n;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_drive_gate: assert property (
		$past(output_drive_n) |-> data_lines_oe_n)
		else $error("data pins driven with output drive high");
	chk_parity_gate: assert property (
		$past(output_drive_n) |-> parity_lines_oe_n)
		else $error("parity pins driven with output drive high");
	chk_oe_pair: assert property (
		parity_lines_oe_n == data_lines_oe_n)
		else $error("parity and data enables differ");
	chk_read_drive: assert property (
		(ld && sel && write_n)
		##1 (qual && !output_drive_n && !(ld && sel && !write_n))
		|=> !data_lines_oe_n)
		else $error("read data not driven one edge later");
	chk_wdata_off: assert property (
		(ld && sel && !write_n) |=> data_lines_oe_n)
		else $error("pins driven while host sends write data");
	chk_write_off: assert property (
		(ld && sel && !write_n) ##1 qual |=> data_lines_oe_n)
		else $error("pins driven in write data phase");
	chk_desel_off: assert property (
		(ld && !sel) ##1 qual |=> data_lines_oe_n)
		else $error("pins driven after deselect");
	chk_stall_data: assert property (
		clock_qualify_n |=> $stable({parity_lines_out, data_lines_out}))
		else $error("outputs changed on ignored edge");
	chk_stall_oe: assert property (
		(clock_qualify_n && !output_drive_n && !$past(output_drive_n))
		|=> $stable(data_lines_oe_n))
		else $error("enable changed while stretched");
endmodule // sdp_port_assertions

bind sdp_data_port sdp_port_assertions u_chk (.core_clk, .reset,
	.clock_qualify_n, .chip_sel1_n, .chip_sel2, .chip_sel3_n, .load_n,
	.write_n, .output_drive_n, .data_lines_out, .data_lines_oe_n,
	.parity_lines_out, .parity_lines_oe_n);

/* tb/tb_top.sv */
// self-checking bench for the sram data port
`timescale 1ns/1ps
module tb_top;
	import sdp_pkg::*;
	logic core_clk = 0, reset = 1, clock_qualify_n = 0, chip_sel1_n = 1;
	logic chip_sel2 = 0, chip_sel3_n = 1, load_n = 0, write_n = 1;
	logic output_drive_n = 0, mode_strap = 1, send = 0;
	logic data_lines_oe_n, parity_lines_oe_n;
	logic [3:0] byte_lane_write_n = '1, parity_lines_in, parity_lines_out;
	logic [17:0] addr = '0;
	logic [31:0] data_lines_in, data_lines_out;
	logic [35:0] word = '0, pins;
	int failures = 0, check_count = 0;

	assign data_lines_in = data_lines_oe_n ? pins[31:0] : data_lines_out;
	assign parity_lines_in = parity_lines_oe_n ? pins[35:32] :
		parity_lines_out;

	sdp_data_port u_dut (.core_clk, .reset, .clock_qualify_n, .chip_sel1_n,
		.chip_sel2, .chip_sel3_n, .load_n, .write_n, .byte_lane_write_n,
		.addr, .output_drive_n, .mode_strap, .data_lines_in,
		.data_lines_out, .data_lines_oe_n, .parity_lines_in,
		.parity_lines_out, .parity_lines_oe_n);
	sdp_host_model u_host (.core_clk, .send, .word, .pins);

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic step(logic ld, wr, sel, logic [17:0] a, logic [3:0] ln);
		@(posedge core_clk);
		load_n <= ld;
		write_n <= wr;
		chip_sel1_n <= !sel;
		chip_sel2 <= sel;
		chip_sel3_n <= !sel;
		addr <= a;
		byte_lane_write_n <= ln;
	endtask

	task automatic check(string nm, logic [36:0] e, g);
		check_count++;
		if (e !== g)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(logic [17:0] a, logic [3:0] ln, logic [35:0] w);
		step(0, 0, 1, a, ln);
		step(0, 1, 0, 0, '1);
		send <= 1;
		word <= w;
		step(0, 1, 0, 0, '1);
		send <= 0;
	endtask

	task automatic rd(logic [17:0] a, logic [35:0] e);
		logic [36:0] got;
		step(0, 1, 1, a, '1);
		step(0, 1, 0, 0, '1);
		step(0, 1, 0, 0, '1);
		@(negedge core_clk);
		got = {data_lines_oe_n, parity_lines_out, data_lines_out};
		if (output_drive_n)
			got[35:0] = e;
		check("read", {output_drive_n, e}, got);
	endtask

	task automatic t_lanes;
		wr(18'h40, '0, 36'h1_1122_3344);
		rd(18'h40, 36'h1_1122_3344);
		wr(18'h40, 4'hd, 36'he_aabb_ccdd);
		rd(18'h40, 36'h3_1122_cc44);
		@(posedge core_clk);
		output_drive_n <= 1;
		rd(18'h40, 36'h3_1122_cc44);
		@(posedge core_clk);
		output_drive_n <= 0;
		$display("lanes and drive done");
	endtask

	task automatic t_stall;
		step(0, 1, 1, 18'h40, '1);
		step(0, 1, 0, 0, '1);
		clock_qualify_n <= 1;
		repeat (3) @(posedge core_clk);
		clock_qualify_n <= 0;
		#1;
		check("early", 37'h1, {36'h0, data_lines_oe_n});
		@(posedge core_clk);
		clock_qualify_n <= 1;
		repeat (3) @(posedge core_clk);
		clock_qualify_n <= 0;
		#1;
		check("held", {1'b0, 36'h3_1122_cc44},
			{data_lines_oe_n, parity_lines_out, data_lines_out});
		@(posedge core_clk);
		#1;
		check("release", 37'h1, {36'h0, data_lines_oe_n});
		$display("stall done");
	endtask

	task automatic t_turn;
		step(0, 1, 1, 18'h40, '1);
		step(0, 0, 1, 18'h80, '0);
		step(0, 1, 1, 18'h80, '1);
		send <= 1;
		word <= 36'h5_a5a5_5a5a;
		@(negedge core_clk);
		check("turn", 37'h1, {36'h0, data_lines_oe_n});
		step(0, 1, 0, 0, '1);
		send <= 0;
		step(0, 1, 0, 0, '1);
		@(negedge core_clk);
		check("forward", {1'b0, 36'h5_a5a5_5a5a},
			{data_lines_oe_n, parity_lines_out, data_lines_out});
		rd(18'h80, 36'h5_a5a5_5a5a);
		$display("turnaround done");
	endtask

	task automatic t_burst(logic il);
		logic [3:0] a;
		@(posedge core_clk);
		reset <= 1;
		mode_strap <= il;
		repeat (2) @(posedge core_clk);
		reset <= 0;
		for (int i = 0; i < 4; i++)
			wr(18'h100 + 18'(i), '0, {9{4'(i)}});
		step(0, 1, 1, 18'h101, '1);
		step(1, 1, 1, 0, '1);
		for (int k = 0; k < 4; k++)
		begin
			step(k < 2 ? 1'b1 : 1'b0, 1, 0, 0, '1);
			@(negedge core_clk);
			a = il ? 4'(1 ^ k) : 4'((1 + k) % 4);
			check("burst", {1'b0, {9{a}}},
				{data_lines_oe_n, parity_lines_out, data_lines_out});
		end
		$display("burst order %0d done", il);
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk);
		reset <= 0;
		t_lanes;
		t_stall;
		t_turn;
		t_burst(1);
		t_burst(0);
		conclude;
	end
endmodule // tb_top
